/* pkg/uart_rx_params.svh */
// Register map, field positions, reset values and sample timing of the receiver
`ifndef UART_RX_PARAMS_SVH
`define UART_RX_PARAMS_SVH
`define OFS_DATA 5'h00
`define OFS_STAT 5'h04
`define OFS_CTLB 5'h08
`define OFS_CTLC 5'h0C
`define OFS_BAUD 5'h10
`define ST_RXC 7
`define ST_FE 4
`define ST_DOR 3
`define ST_UPE 2
`define ST_DBL 1
`define CB_RXCIE 7
`define CB_RXEN 4
`define CB_SIZE2 2
`define CB_RXB8 1
`define CC_PEN 5
`define CC_PODD 4
`define CC_STOP 3
`define CC_SIZE 1
`define CTLC_RST 8'h06
`define BAUD_RST 12'h000
`define SPB_NORM 5'h10
`define SPB_DBL 5'h08
`define VOTE_NORM 5'h08
`define VOTE_DBL 5'h04
`define RESP_OK 2'h0
`define RESP_ERR 2'h2
`endif

/* pkg/uart_rx_pkg.sv */
// Types shared by the serial receiver
`default_nettype none
package uart_rx_pkg;
    typedef struct packed {
        logic [8:0] data;
        logic       fe;
        logic       dor;
        logic       upe;
    } rx_entry_type;
    typedef enum logic [1:0] {ST_IDLE, ST_START, ST_BITS} rx_state_type;
endpackage
`default_nettype wire

/* core/uart_rx.sv */
// Serial receiver with start qualification, two-entry buffer and AXI4-Lite registers
//////////////////////////////////////////////////////////////////////////////
// Contract
// - Receive-complete flag is high exactly while the buffer holds unread frames
// - Clearing receiver enable flushes the buffer, flag reads zero
// - Interrupt requested as long as flag set, enable and global enable on
// - Error bits stored per entry; data read advances to next entry
// - Software writes to the three error bit positions are ignored
// - Error flags never raise an interrupt
// - Frame error is one when first stop bit sampled zero
// - Only the first stop bit is checked, stop count irrelevant
// - Overrun when buffer full, character waiting, and new start detected
// - Overrun cleared once a frame moves from shift stage into buffer
// - Parity error reads zero when checking disabled; a flag stored with an entry still reads after a later disable
// - Checking only with parity enable bit; type bit picks the mode
// - Parity error set only if failed and enabled on arrival; held until read
// - Disable stops reception at once and releases the input pin
// - Input sampled at 16 times baud, or 8 in double speed
// - Start detection on high-to-low edge, first low sample is sample 1
// - Start qualified by vote of samples 8,9,10 or 4,5,6
// - Two or more high votes reject the start as noise
// - Valid start realigns bit sampling, repeated every frame
// - Every bit decided by vote of three centre samples
// - Unused upper data bits read as zero
// - Ninth bit shown in control register b for the same entry
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
`default_nettype none
`include "uart_rx_params.svh"
module uart_rx
    import uart_rx_pkg::*;
(
    input  wire logic        MCLK_IN,
    input  wire logic        RESET_IN,
    input  wire logic        RXD_IN,
    input  wire logic        GIE_IN,
    output logic             RXD_OWN_OUT,
    output logic             RX_IRQ_OUT,
    input  wire logic        AWVALID_IN,
    output logic             AWREADY_OUT,
    input  wire logic [4:0]  AWADDR_IN,
    input  wire logic        WVALID_IN,
    output logic             WREADY_OUT,
    input  wire logic [31:0] WDATA_IN,
    input  wire logic [3:0]  WSTRB_IN,
    output logic             BVALID_OUT,
    input  wire logic        BREADY_IN,
    output logic [1:0]       BRESP_OUT,
    input  wire logic        ARVALID_IN,
    output logic             ARREADY_OUT,
    input  wire logic [4:0]  ARADDR_IN,
    output logic             RVALID_OUT,
    input  wire logic        RREADY_IN,
    output logic [31:0]      RDATA_OUT,
    output logic [1:0]       RRESP_OUT
);
    // Control registers
    logic         rxen_r;
    logic         rxcie_r;
    logic         size2_r;
    logic         dbl_r;
    logic         pen_r;
    logic         podd_r;
    logic         stop_r;
    logic [1:0]   sizec_r;
    logic [11:0]  baud_r;
    // Bus state
    logic         aw_rdy_r;
    logic         w_rdy_r;
    logic         aw_have_r;
    logic         w_have_r;
    logic [4:0]   aw_addr_r;
    logic [31:0]  w_data_r;
    logic [3:0]   w_strb_r;
    logic         bvalid_r;
    logic [1:0]   bresp_r;
    logic         ar_rdy_r;
    logic         rvalid_r;
    logic [31:0]  rdata_r;
    logic [1:0]   rresp_r;
    logic [31:0]  rd_word;
    // Receiver state
    logic [11:0]  div_r;
    logic         tick_r;
    rx_state_type state_r;
    logic [4:0]   samp_r;
    logic [2:0]   vote_r;
    logic         last_r;
    logic [3:0]   idx_r;
    logic [8:0]   shift_r;
    logic         par_r;
    logic         done_r;
    rx_entry_type done_entry_r;
    logic         start_ok_r;
    // Buffer state
    rx_entry_type buf_r [2];
    rx_entry_type hold_r;
    logic         hold_full_r;
    logic         ovr_r;
    logic         wr_r;
    logic         rd_r;
    logic [1:0]   cnt_r;
    logic         irq_r;
    // Derived terms
    logic [4:0]   spb;
    logic [4:0]   vdec;
    logic [2:0]   vote_nxt;
    logic         bit_v;
    logic [3:0]   ndata;
    logic         pop;
    logic         move;
    logic         ovr_set;
    logic         do_wr;

    // A literal cannot be bit-selected, so the reset word goes through a constant
    localparam logic [7:0] ctlc_init = `CTLC_RST;

    function automatic logic mapped(input logic [4:0] a);
        return a == `OFS_DATA || a == `OFS_STAT || a == `OFS_CTLB
            || a == `OFS_CTLC || a == `OFS_BAUD;
    endfunction

    function automatic logic maj3(input logic [2:0] v);
        return (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
    endfunction

    // Reserved size codes fall back to 5..7 bits by their low two bits
    function automatic logic [3:0] data_bits(input logic [2:0] sz);
        return (sz == 3'h7) ? 4'h9 : {2'h0, sz[1:0]} + 4'h5;
    endfunction

    assign spb      = dbl_r ? `SPB_DBL : `SPB_NORM;
    // samp_r trails the tick's sample number by one, so this is the third voter
    assign vdec     = (dbl_r ? `VOTE_DBL : `VOTE_NORM) + 5'h01;
    assign vote_nxt = {vote_r[1:0], RXD_IN};
    assign bit_v    = maj3(vote_nxt);
    assign ndata    = data_bits({size2_r, sizec_r});
    assign pop      = ARVALID_IN && ar_rdy_r && ARADDR_IN == `OFS_DATA && cnt_r != 2'h0;
    assign move     = hold_full_r && (cnt_r != 2'h2 || pop);
    assign ovr_set  = start_ok_r && hold_full_r && cnt_r == 2'h2;
    assign do_wr    = aw_have_r && w_have_r && !bvalid_r;

    assign AWREADY_OUT = aw_rdy_r;
    assign WREADY_OUT  = w_rdy_r;
    assign BVALID_OUT  = bvalid_r;
    assign BRESP_OUT   = bresp_r;
    assign ARREADY_OUT = ar_rdy_r;
    assign RVALID_OUT  = rvalid_r;
    assign RDATA_OUT   = rdata_r;
    assign RRESP_OUT   = rresp_r;
    assign RX_IRQ_OUT  = irq_r;
    assign RXD_OWN_OUT = rxen_r;

    //////////////////////////////////////////////////////////////////////////
    // Sample tick: one pulse every baud_r+1 clocks, held off while disabled
    always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            div_r  <= 12'h000;
            tick_r <= 1'b0;
        end else if (!rxen_r) begin
            div_r  <= 12'h000;
            tick_r <= 1'b0;
        end else if (div_r == baud_r) begin
            div_r  <= 12'h000;
            tick_r <= 1'b1;
        end else begin
            div_r  <= div_r + 12'h001;
            tick_r <= 1'b0;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Clock and data recovery
    always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            state_r      <= ST_IDLE;
            samp_r       <= 5'h00;
            vote_r       <= 3'h7;
            last_r       <= 1'b1;
            idx_r        <= 4'h0;
            shift_r      <= 9'h000;
            par_r        <= 1'b0;
            done_r       <= 1'b0;
            done_entry_r <= '0;
            start_ok_r   <= 1'b0;
        end else begin
            done_r     <= 1'b0;
            start_ok_r <= 1'b0;
            if (!rxen_r) begin
                state_r <= ST_IDLE;
                last_r  <= 1'b1;
            end else if (tick_r) begin
                unique case (state_r)
                    ST_IDLE: begin
                        last_r <= RXD_IN;
                        if (last_r && !RXD_IN) begin
                            state_r <= ST_START;
                            samp_r  <= 5'h01;
                            shift_r <= 9'h000;
                            idx_r   <= 4'h0;
                        end
                    end
                    ST_START, ST_BITS: begin
                        vote_r <= vote_nxt;
                        samp_r <= (samp_r == spb) ? 5'h01 : samp_r + 5'h01;
                        if (samp_r == spb) begin
                            state_r <= ST_BITS;
                            if (state_r == ST_BITS) begin
                                idx_r <= idx_r + 4'h1;
                            end
                        end
                        if (samp_r == vdec) begin
                            if (state_r == ST_START) begin
                                if (bit_v) begin
                                    state_r <= ST_IDLE;
                                    last_r  <= RXD_IN;
                                end else begin
                                    start_ok_r <= 1'b1;
                                end
                            end else if (idx_r < ndata) begin
                                shift_r[idx_r] <= bit_v;
                            end else if (idx_r == ndata && pen_r) begin
                                par_r <= bit_v;
                            end else begin
                                // First stop bit ends the frame, any second one is ignored
                                done_r            <= 1'b1;
                                done_entry_r.data <= shift_r;
                                done_entry_r.fe   <= !bit_v;
                                done_entry_r.dor  <= 1'b0;
                                done_entry_r.upe  <= pen_r && (par_r != (^shift_r ^ podd_r));
                                state_r           <= ST_IDLE;
                                last_r            <= RXD_IN;
                            end
                        end
                    end
                endcase
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Shift stage hold and two-entry buffer
    always_ff @(posedge MCLK_IN) begin
        if (move) begin
            buf_r[wr_r]     <= hold_r;
            buf_r[wr_r].dor <= ovr_r || ovr_set;
        end
    end

    always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            hold_r      <= '0;
            hold_full_r <= 1'b0;
            ovr_r       <= 1'b0;
            wr_r        <= 1'b0;
            rd_r        <= 1'b0;
            cnt_r       <= 2'h0;
        end else if (!rxen_r) begin
            hold_full_r <= 1'b0;
            ovr_r       <= 1'b0;
            wr_r        <= 1'b0;
            rd_r        <= 1'b0;
            cnt_r       <= 2'h0;
        end else begin
            cnt_r <= cnt_r + {1'b0, move} - {1'b0, pop};
            if (move) begin
                wr_r <= ~wr_r;
            end
            if (pop) begin
                rd_r <= ~rd_r;
            end
            // A frame finishing while the stage is still blocked is lost
            if (done_r && (!hold_full_r || move)) begin
                hold_r      <= done_entry_r;
                hold_full_r <= 1'b1;
            end else if (move) begin
                hold_full_r <= 1'b0;
            end
            ovr_r <= ovr_set || (ovr_r && !move);
        end
    end

    always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= rxcie_r && GIE_IN && cnt_r != 2'h0;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Register write side
    always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            aw_rdy_r  <= 1'b1;
            w_rdy_r   <= 1'b1;
            aw_have_r <= 1'b0;
            w_have_r  <= 1'b0;
            aw_addr_r <= 5'h00;
            w_data_r  <= 32'h00000000;
            w_strb_r  <= 4'h0;
            bvalid_r  <= 1'b0;
            bresp_r   <= `RESP_OK;
        end else begin
            if (AWVALID_IN && aw_rdy_r) begin
                aw_have_r <= 1'b1;
                aw_addr_r <= AWADDR_IN;
                aw_rdy_r  <= 1'b0;
            end
            if (WVALID_IN && w_rdy_r) begin
                w_have_r <= 1'b1;
                w_data_r <= WDATA_IN;
                w_strb_r <= WSTRB_IN;
                w_rdy_r  <= 1'b0;
            end
            if (do_wr) begin
                aw_have_r <= 1'b0;
                w_have_r  <= 1'b0;
                bvalid_r  <= 1'b1;
                bresp_r   <= mapped(aw_addr_r) ? `RESP_OK : `RESP_ERR;
            end
            if (bvalid_r && BREADY_IN) begin
                bvalid_r <= 1'b0;
                aw_rdy_r <= 1'b1;
                w_rdy_r  <= 1'b1;
            end
        end
    end

    always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            rxen_r  <= 1'b0;
            rxcie_r <= 1'b0;
            size2_r <= 1'b0;
            dbl_r   <= 1'b0;
            pen_r   <= ctlc_init[`CC_PEN];
            podd_r  <= ctlc_init[`CC_PODD];
            stop_r  <= ctlc_init[`CC_STOP];
            sizec_r <= ctlc_init[`CC_SIZE+:2];
            baud_r  <= `BAUD_RST;
        end else if (do_wr) begin
            if (w_strb_r[0]) begin
                unique case (aw_addr_r)
                    `OFS_STAT: dbl_r <= w_data_r[`ST_DBL];
                    `OFS_CTLB: begin
                        rxcie_r <= w_data_r[`CB_RXCIE];
                        rxen_r  <= w_data_r[`CB_RXEN];
                        size2_r <= w_data_r[`CB_SIZE2];
                    end
                    `OFS_CTLC: begin
                        pen_r   <= w_data_r[`CC_PEN];
                        podd_r  <= w_data_r[`CC_PODD];
                        stop_r  <= w_data_r[`CC_STOP];
                        sizec_r <= w_data_r[`CC_SIZE+:2];
                    end
                    `OFS_BAUD: baud_r[7:0] <= w_data_r[7:0];
                    default: ;
                endcase
            end
            if (w_strb_r[1] && aw_addr_r == `OFS_BAUD) begin
                baud_r[11:8] <= w_data_r[11:8];
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Register read side; a data read pops the buffer
    always_comb begin
        rd_word = 32'h00000000;
        unique case (ARADDR_IN)
            // Entries are never reset, so an empty buffer reads zero
            `OFS_DATA: rd_word[7:0] = (cnt_r != 2'h0) ? buf_r[rd_r].data[7:0] : 8'h00;
            `OFS_STAT: begin
                rd_word[`ST_RXC] = cnt_r != 2'h0;
                rd_word[`ST_FE]  = cnt_r != 2'h0 && buf_r[rd_r].fe;
                rd_word[`ST_DOR] = cnt_r != 2'h0 && buf_r[rd_r].dor;
                rd_word[`ST_UPE] = cnt_r != 2'h0 && buf_r[rd_r].upe;
                rd_word[`ST_DBL] = dbl_r;
            end
            `OFS_CTLB: begin
                rd_word[`CB_RXCIE] = rxcie_r;
                rd_word[`CB_RXEN]  = rxen_r;
                rd_word[`CB_SIZE2] = size2_r;
                rd_word[`CB_RXB8]  = cnt_r != 2'h0 && buf_r[rd_r].data[8];
            end
            `OFS_CTLC: begin
                rd_word[`CC_PEN]      = pen_r;
                rd_word[`CC_PODD]     = podd_r;
                rd_word[`CC_STOP]     = stop_r;
                rd_word[`CC_SIZE+:2]  = sizec_r;
            end
            `OFS_BAUD: rd_word[11:0] = baud_r;
            default: ;
        endcase
    end

    always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            ar_rdy_r <= 1'b1;
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h00000000;
            rresp_r  <= `RESP_OK;
        end else begin
            if (ARVALID_IN && ar_rdy_r) begin
                ar_rdy_r <= 1'b0;
                rvalid_r <= 1'b1;
                rdata_r  <= rd_word;
                rresp_r  <= mapped(ARADDR_IN) ? `RESP_OK : `RESP_ERR;
            end
            if (rvalid_r && RREADY_IN) begin
                rvalid_r <= 1'b0;
                ar_rdy_r <= 1'b1;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (RESET_IN);

    sequence s_edge;
        state_r == ST_IDLE && rxen_r && tick_r && last_r && !RXD_IN;
    endsequence
    sequence s_reject;
        state_r == ST_START && rxen_r && tick_r && samp_r == vdec && bit_v;
    endsequence

    property p_flush;
        !rxen_r |=> cnt_r == 2'h0 && !hold_full_r;
    endproperty
    a_flush: assert property (p_flush) else $error("buffer not flushed");

    property p_irq;
        rxcie_r && GIE_IN && cnt_r != 2'h0 |=> RX_IRQ_OUT;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt missing");

    property p_irq_cause;
        RX_IRQ_OUT |-> $past(cnt_r) != 2'h0;
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("interrupt without data");

    property p_start;
        s_edge |=> state_r == ST_START && samp_r == 5'h01;
    endproperty
    a_start: assert property (p_start) else $error("start not detected");

    property p_reject;
        s_reject |=> state_r == ST_IDLE;
    endproperty
    a_reject: assert property (p_reject) else $error("noise start accepted");

    property p_upe;
        done_r && done_entry_r.upe |-> $past(pen_r, 1);
    endproperty
    a_upe: assert property (p_upe) else $error("parity error while off");

    property p_dor_clr;
        rxen_r && move && !ovr_set |=> !ovr_r;
    endproperty
    a_dor_clr: assert property (p_dor_clr) else $error("overrun not cleared");

    property p_pop;
        rxen_r && pop && !move |=> cnt_r == $past(cnt_r) - 2'h1;
    endproperty
    a_pop: assert property (p_pop) else $error("read did not advance");

    property p_bit_period;
        rxen_r && tick_r && state_r == ST_BITS && samp_r == spb |=> samp_r == 5'h01;
    endproperty
    a_bit_period: assert property (p_bit_period) else $error("bit period wrong");
endmodule // uart_rx
`default_nettype wire

/* verif/uart_tx_model.sv */
// Behavioural serial transmitter driving the receive line
`timescale 1ns/1ps
`default_nettype none
module uart_tx_model (
    input  wire logic clk_in,
    output logic      line_out
);
    // Line rests high between frames, as a pulled-up pin would
    initial line_out = 1'h1;
    task automatic hold(input logic v, input int n);
        line_out <= v;
        repeat (n) @(posedge clk_in);
    endtask
    // LSB first; flip sends a wrong parity bit, stop is the first stop level
    task automatic send(input logic [8:0] d, input int nb, input logic pen, input logic odd,
                        input logic flip, input logic stop, input int spb);
        logic par;
        par = odd ^ flip;
        hold(1'h0, spb);
        for (int i = 0; i < nb; i++) begin
            hold(d[i], spb);
            par = par ^ d[i];
        end
        if (pen) hold(par, spb);
        hold(stop, spb);
        hold(1'h1, spb);
    endtask
endmodule // uart_tx_model
`default_nettype wire

/* verif/tb.sv */
// Self-checking bench for the serial receiver
`timescale 1ns/1ps
`default_nettype none
`include "uart_rx_params.svh"
module tb;
    typedef struct packed {
        logic       sz2;
        logic [7:0] ctlc;
        logic       dbl;
        logic [8:0] d;
        logic       flip;
        logic       stop;
    } row_type;
    logic        clk, rst, gie, own, irq, line;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [4:0]  addr;
    logic [31:0] wdata, rdata, rd;
    logic [1:0]  bresp, rresp, rsp;
    logic [7:0]  mask;
    int          err_total = 0, compares = 0, cyc = 0, nb;
    row_type     r;
    // Size bit, format, speed, data, bad parity, first stop level
    row_type     rows [10] = '{
        '{1'h0, 8'h06, 1'h0, 9'h0A5, 1'h0, 1'h1}, '{1'h0, 8'h00, 1'h0, 9'h1F5, 1'h0, 1'h1},
        '{1'h0, 8'h26, 1'h0, 9'h0C3, 1'h0, 1'h1}, '{1'h0, 8'h26, 1'h0, 9'h0C3, 1'h1, 1'h1},
        '{1'h0, 8'h36, 1'h0, 9'h081, 1'h0, 1'h1}, '{1'h0, 8'h36, 1'h0, 9'h081, 1'h1, 1'h1},
        '{1'h0, 8'h06, 1'h1, 9'h05A, 1'h0, 1'h1}, '{1'h1, 8'h06, 1'h0, 9'h1A5, 1'h0, 1'h1},
        '{1'h0, 8'h0E, 1'h0, 9'h07E, 1'h0, 1'h0}, '{1'h0, 8'h06, 1'h0, 9'h03C, 1'h0, 1'h0}};
    uart_rx uart_rx_i (.MCLK_IN(clk), .RESET_IN(rst), .RXD_IN(line), .GIE_IN(gie), .RXD_OWN_OUT(own),
        .RX_IRQ_OUT(irq), .AWVALID_IN(awvalid), .AWREADY_OUT(awready), .AWADDR_IN(addr),
        .WVALID_IN(wvalid), .WREADY_OUT(wready), .WDATA_IN(wdata), .WSTRB_IN(4'hF), .BVALID_OUT(bvalid),
        .BREADY_IN(bready), .BRESP_OUT(bresp), .ARVALID_IN(arvalid), .ARREADY_OUT(arready),
        .ARADDR_IN(addr), .RVALID_OUT(rvalid), .RREADY_IN(rready), .RDATA_OUT(rdata), .RRESP_OUT(rresp));
    uart_tx_model uart_tx_model_i (.clk_in(clk), .line_out(line));
    ////////////////////////////////
    always #25 clk = ~clk;
    // Far above the few thousand cycles the sequence needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            err_total++;
            summarize();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("err_total=%0d compares=%0d", err_total, compares);
        if (err_total == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Write when wr, else read; each channel dropped at its own handshake
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        logic ta, tw;
        ta = 1'h0;
        tw = !wr;
        @(posedge clk);
        {awvalid, wvalid, bready} <= {3{wr}};
        {arvalid, rready} <= {2{!wr}};
        addr <= a;
        wdata <= d;
        forever begin
            @(posedge clk);
            if (!ta && (wr ? awready : arready) === 1'h1) begin
                ta = 1'h1;
                {awvalid, arvalid} <= 2'h0;
            end
            if (!tw && wready === 1'h1) begin
                tw = 1'h1;
                wvalid <= 1'h0;
            end
            if ((wr ? bvalid : rvalid) === 1'h1) break;
        end
        {bready, rready} <= 2'h0;
        rd = rdata;
        rsp = wr ? bresp : rresp;
    endtask
    task automatic rdchk(input logic [4:0] a, input logic [31:0] e);
        bus(1'h0, a, 32'h0);
        chk(rd, e);
    endtask
    ////////////////////////////////
    initial begin
        clk = 1'h0;
        rst = 1'h1;
        {gie, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        addr = 5'h00;
        wdata = 32'h0;
        repeat (20) @(posedge clk);
        rst <= 1'h0;
        rdchk(`OFS_CTLC, {24'h0, `CTLC_RST});
        rdchk(`OFS_CTLB, 32'h0);
        rdchk(`OFS_STAT, 32'h0);
        rdchk(5'h14, 32'h0);
        chk({30'h0, rsp}, {30'h0, `RESP_ERR});
        chk({31'h0, own}, 32'h0);
        for (int k = 0; k < 10; k++) begin
            r = rows[k];
            nb = r.sz2 ? 9 : 5 + int'(r.ctlc[2:1]);
            mask = (nb > 7) ? 8'hFF : 8'hFF >> (8 - nb);
            bus(1'h1, `OFS_CTLC, {24'h0, r.ctlc});
            bus(1'h1, `OFS_CTLB, {27'h0, 1'h1, 1'h0, r.sz2, 2'h0});
            bus(1'h1, `OFS_STAT, {30'h0, r.dbl, 1'h0});
            chk({31'h0, own}, 32'h1);
            uart_tx_model_i.send(r.d, nb, r.ctlc[5], r.ctlc[4], r.flip, r.stop, r.dbl ? 8 : 16);
            chk({31'h0, irq}, 32'h0);
            rdchk(`OFS_STAT, {24'h0, 1'h1, 2'h0, !r.stop, 1'h0, r.ctlc[5] & r.flip, r.dbl, 1'h0});
            bus(1'h0, `OFS_CTLB, 32'h0);
            chk({31'h0, rd[1]}, {31'h0, nb == 9 && r.d[8]});
            rdchk(`OFS_DATA, {24'h0, r.d[7:0] & mask});
            rdchk(`OFS_STAT, {30'h0, r.dbl, 1'h0});
        end
        uart_tx_model_i.hold(1'h0, 7);
        uart_tx_model_i.hold(1'h1, 32);
        rdchk(`OFS_STAT, 32'h0);
        // Nine low samples: votes 8,9,10 see low, low, high and accept the start
        uart_tx_model_i.hold(1'h0, 9);
        uart_tx_model_i.hold(1'h1, 200);
        rdchk(`OFS_STAT, 32'h80);
        rdchk(`OFS_DATA, 32'hFF);
        for (int k = 1; k < 5; k++) uart_tx_model_i.send(9'(k * 17), 8, 1'h0, 1'h0, 1'h0, 1'h1, 16);
        bus(1'h1, `OFS_STAT, 32'h1C);
        chk({30'h0, rsp}, {30'h0, `RESP_OK});
        rdchk(`OFS_STAT, 32'h80);
        rdchk(`OFS_DATA, 32'h11);
        rdchk(`OFS_STAT, 32'h80);
        rdchk(`OFS_DATA, 32'h22);
        rdchk(`OFS_STAT, 32'h88);
        rdchk(`OFS_DATA, 32'h33);
        rdchk(`OFS_STAT, 32'h0);
        uart_tx_model_i.send(9'h055, 8, 1'h0, 1'h0, 1'h0, 1'h1, 16);
        rdchk(`OFS_STAT, 32'h80);
        while (rd[7] === 1'h1) begin
            bus(1'h0, `OFS_DATA, 32'h0);
            bus(1'h0, `OFS_STAT, 32'h0);
        end
        chk(rd, 32'h0);
        bus(1'h1, `OFS_CTLB, 32'h90);
        gie <= 1'h1;
        uart_tx_model_i.send(9'h066, 8, 1'h0, 1'h0, 1'h0, 1'h1, 16);
        chk({31'h0, irq}, 32'h1);
        gie <= 1'h0;
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        // Receiver switched off in the middle of a frame
        fork
            uart_tx_model_i.send(9'h077, 8, 1'h0, 1'h0, 1'h0, 1'h1, 16);
            begin
                repeat (60) @(posedge clk);
                bus(1'h1, `OFS_CTLB, 32'h0);
            end
        join
        chk({31'h0, own}, 32'h0);
        rdchk(`OFS_STAT, 32'h0);
        bus(1'h1, `OFS_CTLB, 32'h10);
        repeat (40) @(posedge clk);
        rdchk(`OFS_STAT, 32'h0);
        summarize();
    end
endmodule // tb
`default_nettype wire
